// ==== core/ssr_defines.svh ====
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// Behaviour
// - Manual reset low at least 25 us counts
// - Reset follows valid manual reset after 12 us
// - Reset holds while manual reset stays low
// - Mode pin grounded selects internal thresholds
// - Mode pin above 600 mV selects external
// - External mode uses sense and mode comparators
// - Internal mode: warning precedes reset on fall
// - Internal warning trips above reset, hysteretic
// - Warning output high while supply is good
// - Undervoltage or manual reset asserts reset
// - Reset stretched 200 ms after causes clear
// - Reset clears counters, watchdog outputs high
// - Reset blocks chip select, output held high
// - Active-high reset mirrors active-low reset

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SSR_CLK_MHZ 250
`define SSR_MR_MIN_US 25
`define SSR_MR_DLY_US 12
`define SSR_STRETCH_MS 200
// Glitch filter length, least time in clock cycles
`define SSR_MR_MIN_CYC (`SSR_MR_MIN_US * `SSR_CLK_MHZ)
// Propagation delay of a valid press
`define SSR_MR_DLY_CYC (`SSR_MR_DLY_US * `SSR_CLK_MHZ)
`define SSR_STRETCH_CYC (`SSR_STRETCH_MS * 1000 * `SSR_CLK_MHZ)
`define SSR_CNT_W 26
`endif

// ==== core/ssr_pkg.sv ====
package ssr_pkg;
  // Threshold selection
  typedef enum logic {SSR_MODE_INT, SSR_MODE_EXT} ssr_mode_t;
  // Reset sequencer states
  typedef enum logic [1:0] {
    SSR_IDLE, SSR_MR_WAIT, SSR_HOLD, SSR_STRETCH
  } ssr_state_t;
endpackage

// ==== core/ssr_cmp_if.sv ====
// Comparator decisions bundled from the selector
interface ssr_cmp_if;
  logic mode_ext;
  logic warn_low;
  logic rst_low;
  modport src (output mode_ext, output warn_low, output rst_low);
  modport dst (input mode_ext, input warn_low, input rst_low);
endinterface

// ==== core/ssr_sel.sv ====
`include "ssr_defines.svh"
// ---------------------------------------------------------------
// Threshold mode selection and warning hysteresis
// ---------------------------------------------------------------
module ssr_sel
  import ssr_pkg::*;
(
  // Clocking
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Comparator levels
  input wire logic mode_above_sel,
  input wire logic int_warn_trip,
  input wire logic int_warn_clear,
  input wire logic int_rst_low,
  input wire logic ext_warn_low,
  input wire logic ext_rst_low,
  // Decisions
  ssr_cmp_if.src cmp
);
  logic hyst_q; // Internal warning latch
  ssr_mode_t mode;

  // Mode from the select comparator
  assign mode = mode_above_sel ? SSR_MODE_EXT : SSR_MODE_INT;

  // Set at trip point, clear only above the hysteresis band
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Idle like the output register, so no false warning after reset
      hyst_q <= 1'b0;
    end else if (ce) begin
      if (int_warn_trip || int_rst_low) begin
        hyst_q <= 1'b1;
      end else if (int_warn_clear) begin
        hyst_q <= 1'b0;
      end
    end
  end

  // External mode ignores the internal divider entirely
  assign cmp.mode_ext = (mode == SSR_MODE_EXT);
  // Set terms pass straight through so in internal mode the warning never trails reset
  assign cmp.warn_low = cmp.mode_ext ? ext_warn_low
    : (hyst_q || int_warn_trip || int_rst_low);
  assign cmp.rst_low = cmp.mode_ext ? ext_rst_low : int_rst_low;

  // Internal warning is up whenever internal reset cause is
  internal_warn_first_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && !mode_above_sel && int_rst_low) |=> hyst_q)
    else $error("warning not ahead of reset");
  hyst_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && !int_warn_trip && !int_rst_low && !int_warn_clear)
    |=> $stable(hyst_q))
    else $error("warning toggled inside band");
endmodule

// ==== core/ssr_top.sv ====
`include "ssr_defines.svh"
// ---------------------------------------------------------------
// Supply supervisor reset sequencer
// ---------------------------------------------------------------
module ssr_top
  import ssr_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = `SSR_STRETCH_CYC,
  parameter int unsigned MR_MIN_CYC = `SSR_MR_MIN_CYC,
  parameter int unsigned MR_DLY_CYC = `SSR_MR_DLY_CYC
) (
  // Clocking
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Manual reset
  input wire logic manual_reset_n,
  // Supply comparators
  input wire logic mode_above_sel,
  input wire logic int_warn_trip,
  input wire logic int_warn_clear,
  input wire logic int_rst_low,
  input wire logic early_warn_sense,
  input wire logic ext_rst_low,
  // Watchdog requests from the neighbour
  input wire logic wd_fault_req,
  input wire logic wd_strobe_req,
  // Chip select
  input wire logic cs_in_n,
  output logic cs_out_n,
  // Reset, warning, watchdog and mode outputs
  output logic reset_n,
  output logic reset_hi,
  output logic early_power_warn_n,
  output logic watchdog_fault_n,
  output logic watchdog_strobe_n,
  output logic mode_ext
);
  ssr_cmp_if cmp ();
  ssr_state_t state_q;
  logic [`SSR_CNT_W-1:0] cnt_q; // Shared phase counter
  logic [`SSR_CNT_W-1:0] mr_cnt_q; // Continuous low counter
  logic mr_valid_q; // Filtered press
  logic rst_q; // Reset asserted
  logic warn_q;
  logic wdf_q;
  logic wds_q;
  logic cs_q;
  logic supply_low;

  // Sense high means sense input below its threshold
  ssr_sel u_sel (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .mode_above_sel(mode_above_sel),
    .int_warn_trip(int_warn_trip),
    .int_warn_clear(int_warn_clear),
    .int_rst_low(int_rst_low),
    .ext_warn_low(early_warn_sense),
    .ext_rst_low(ext_rst_low),
    .cmp(cmp)
  );
  assign supply_low = cmp.rst_low;

  // ---------------------------------------------------------------
  // Manual reset glitch filter
  // ---------------------------------------------------------------
  // Counts continuous low; any high restarts, so short pulses vanish
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mr_cnt_q <= '0;
      mr_valid_q <= 1'b0;
    end else if (ce) begin
      if (manual_reset_n) begin
        mr_cnt_q <= '0;
        mr_valid_q <= 1'b0;
      end else if (mr_cnt_q >= `SSR_CNT_W'(MR_MIN_CYC - 1)) begin
        mr_valid_q <= 1'b1;
      end else begin
        mr_cnt_q <= mr_cnt_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  // Undervoltage asserts at once; a press waits its propagation delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SSR_HOLD;
      cnt_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        SSR_IDLE: begin
          cnt_q <= '0;
          if (supply_low) begin
            state_q <= SSR_HOLD;
          end else if (mr_valid_q) begin
            state_q <= SSR_MR_WAIT;
          end
        end
        SSR_MR_WAIT: begin
          // Delay measured from press validation
          if (supply_low) begin
            state_q <= SSR_HOLD;
            cnt_q <= '0;
          end else if (cnt_q >= `SSR_CNT_W'(MR_DLY_CYC - 1)) begin
            state_q <= SSR_HOLD;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SSR_HOLD: begin
          // Stays while any cause persists
          cnt_q <= '0;
          if (!supply_low && manual_reset_n) begin
            state_q <= SSR_STRETCH;
          end
        end
        SSR_STRETCH: begin
          if (supply_low || !manual_reset_n) begin
            state_q <= SSR_HOLD;
            cnt_q <= '0;
          end else if (cnt_q >= `SSR_CNT_W'(STRETCH_CYC - 1)) begin
            state_q <= SSR_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Registered reset level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 1'b1;
    end else if (ce) begin
      rst_q <= (state_q == SSR_HOLD) || (state_q == SSR_STRETCH)
        || (state_q == SSR_IDLE && supply_low)
        || (state_q == SSR_MR_WAIT && supply_low);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Warning low when the chosen warning comparator trips
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn_q <= 1'b0;
    end else if (ce) begin
      warn_q <= cmp.warn_low;
    end
  end

  // Watchdog outputs forced inactive during reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdf_q <= 1'b1;
      wds_q <= 1'b1;
    end else if (ce) begin
      wdf_q <= !(wd_fault_req && !rst_q);
      wds_q <= !(wd_strobe_req && !rst_q);
    end
  end

  // Chip select blocked during reset; the write grace window is
  // left to the neighbouring gate logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_q <= 1'b1;
    end else if (ce) begin
      cs_q <= rst_q ? 1'b1 : cs_in_n;
    end
  end

  assign reset_n = !rst_q;
  assign reset_hi = rst_q;
  assign early_power_warn_n = !warn_q;
  assign watchdog_fault_n = wdf_q;
  assign watchdog_strobe_n = wds_q;
  assign cs_out_n = cs_q;
  assign mode_ext = cmp.mode_ext;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Cycles in reset with both causes gone, for the stretch check;
  // kept apart from the sequencer counter so the check is independent
  logic [`SSR_CNT_W-1:0] calm_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      calm_q <= '0;
    end else if (ce) begin
      if (!rst_q || supply_low || !manual_reset_n) begin
        calm_q <= '0; // Any cause restarts the count
      end else begin
        calm_q <= calm_q + 1'b1;
      end
    end
  end

  // Press path in steps: end of the delay, then hold and reset
  sequence mr_delay_end_s;
    ce && (state_q == SSR_MR_WAIT) && !supply_low
      && (cnt_q >= `SSR_CNT_W'(MR_DLY_CYC - 1));
  endsequence
  sequence mr_reset_out_s;
    (state_q == SSR_HOLD) ##1 (rst_q || !$past(ce));
  endsequence

  complement_out_a: assert property (
    @(posedge clk) disable iff (!nrst) reset_hi == !reset_n)
    else $error("reset outputs not complementary");
  uv_reset_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && supply_low) ##1 ce |=> rst_q)
    else $error("undervoltage did not assert reset");
  mr_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (rst_q && (state_q != SSR_IDLE) && !manual_reset_n) |=> rst_q)
    else $error("reset dropped while manual reset low");
  wd_force_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && rst_q) |=> (watchdog_fault_n && watchdog_strobe_n))
    else $error("watchdog outputs active in reset");
  cs_block_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && rst_q) |=> cs_out_n)
    else $error("chip select passed in reset");
  glitch_reject_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && manual_reset_n) |=> !mr_valid_q)
    else $error("released press stayed valid");
  stretch_cnt_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(rst_q) |-> (calm_q >= `SSR_CNT_W'(STRETCH_CYC)))
    else $error("reset released without stretch");
  warn_good_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ce && !cmp.warn_low) |=> early_power_warn_n)
    else $error("warning low with good supply");
  mr_delay_a: assert property (
    @(posedge clk) disable iff (!nrst)
    mr_delay_end_s |=> mr_reset_out_s)
    else $error("press delay did not end in reset");
endmodule

// ==== bench/ssr_host_model.sv ====
// ---------------------------------------------------------------
// Processor side: chip select traffic towards the supervisor
// ---------------------------------------------------------------
module ssr_host_model (
  // Clock
  input wire logic clk,
  // Chip select towards the supervisor
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pattern source, never all zero
  logic [3:0] lfsr_q = 4'h1;
  // Careless processor: keeps selecting memory even in reset,
  // so the gate in front of the memory is really exercised
  always @(posedge clk) begin
    lfsr_q <= #0.5 {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
  end
  // Select follows the pattern, changes every few cycles
  assign cs_n = lfsr_q[0];
endmodule

// ==== bench/supply_supervisor_reset_logic_tb.sv ====
// ---------------------------------------------------------------
// Self-checking bench for the reset sequencer
// ---------------------------------------------------------------
module supply_supervisor_reset_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Short counts so the run stays brief
  localparam int STR = 20;
  localparam int MMIN = 5;
  localparam int MDLY = 3;
  // Design inputs
  logic clk = 0, nrst = 0, mr_n = 1, mode = 0, trip = 0, clr = 1;
  logic ilow = 0, sense = 0, elow = 0, wf = 0, ws = 0, cs_in_n;
  logic ce = 1;
  // Design outputs
  logic cs_out_n, reset_n, reset_hi, warn_n, wdf_n, wds_n, mode_ext;
  // Bookkeeping
  int seed = 18, fail_count = 0, n_compared = 0, n;
  logic pr, pf, ps, pc;

  ssr_top #(.STRETCH_CYC(STR), .MR_MIN_CYC(MMIN), .MR_DLY_CYC(MDLY))
  ssr_top_i (
    .clk(clk), .nrst(nrst), .ce(ce), .manual_reset_n(mr_n),
    .mode_above_sel(mode), .int_warn_trip(trip), .int_warn_clear(clr),
    .int_rst_low(ilow), .early_warn_sense(sense), .ext_rst_low(elow),
    .wd_fault_req(wf), .wd_strobe_req(ws), .cs_in_n(cs_in_n),
    .cs_out_n(cs_out_n), .reset_n(reset_n), .reset_hi(reset_hi),
    .early_power_warn_n(warn_n), .watchdog_fault_n(wdf_n),
    .watchdog_strobe_n(wds_n), .mode_ext(mode_ext)
  );
  ssr_host_model ssr_host_model_i (.clk(clk), .cs_n(cs_in_n));

  // Clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end

  // Gated outputs sit high while reset is active
  function automatic logic gate(logic rst_n, logic v);
    return rst_n ? v : 1'b1;
  endfunction

  // One-bit comparison
  task automatic chk(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Advance k edges, then settle past the edge
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Both reset polarities at once
  task automatic chk_rst(logic exp);
    chk("reset_n", exp, reset_n);
    chk("reset_hi", ~exp, reset_hi);
  endtask

  // Bounded wait for a reset level; n returns cycles spent
  task automatic wait_rst(logic lvl, int lim);
    n = 0;
    while (reset_n !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    chk("reset_wait", lvl, reset_n);
  endtask

  // Verdict, the single end of the run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  initial begin
    #40000;
    fail_count++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    wf = 1;
    repeat (16) @(posedge clk);
    #1;
    chk_rst(0);
    chk("wd_fault_n", 1, wdf_n);
    nrst = 1;
    // Good supply: no warning pulse right after reset
    cyc(2);
    chk("warn_n", 1, warn_n);
    chk_rst(0);
    wait_rst(1, STR + 8);
    chk("stretch", 1, n >= STR - 2);
    // Falling supply: warning first, then reset
    trip = 1;
    clr = 0;
    cyc(3);
    chk("warn_n", 0, warn_n);
    chk_rst(1);
    ilow = 1;
    cyc(2);
    chk_rst(0);
    // Recovery inside the hysteresis band keeps the warning
    ilow = 0;
    trip = 0;
    wait_rst(1, STR + 8);
    chk("stretch", 1, n >= STR);
    chk("warn_n", 0, warn_n);
    clr = 1;
    cyc(3);
    chk("warn_n", 1, warn_n);
    // Glitch one edge short of valid is filtered out
    mr_n = 0;
    cyc(MMIN - 1);
    mr_n = 1;
    cyc(MMIN + MDLY + 6);
    chk_rst(1);
    // Valid press: delayed reset, held while low, then stretched
    mr_n = 0;
    cyc(MMIN);
    chk_rst(1);
    wait_rst(0, MDLY + 8);
    chk("press_delay", 1, n >= MDLY && n <= MDLY + 2);
    cyc(30);
    chk_rst(0);
    mr_n = 1;
    wait_rst(1, STR + 8);
    chk("stretch", 1, n >= STR);
    // External mode ignores the internal comparators
    mode = 1;
    ilow = 1;
    trip = 1;
    cyc(3);
    chk("mode_ext", 1, mode_ext);
    chk_rst(1);
    chk("warn_n", 1, warn_n);
    sense = 1;
    elow = 1;
    cyc(3);
    chk("warn_n", 0, warn_n);
    chk_rst(0);
    {sense, elow, ilow, trip, mode} = 5'h00;
    cyc(1);
    chk("mode_ext", 0, mode_ext);
    wait_rst(1, STR + 8);
    chk("stretch", 1, n >= STR);
    // Frozen clock enable ignores a dip until it runs again
    ce = 0;
    ilow = 1;
    cyc(4);
    chk_rst(1);
    ce = 1;
    cyc(2);
    chk_rst(0);
    ilow = 0;
    wait_rst(1, STR + 8);
    chk("stretch", 1, n >= STR);
    // Random traffic with occasional supply dips
    for (int i = 0; i < 400; i++) begin
      wf = $random(seed);
      ws = $random(seed);
      ilow = ($random(seed) & 63) == 0;
      pr = reset_n;
      pf = wf;
      ps = ws;
      pc = cs_in_n;
      cyc(1);
      if (reset_n === pr) begin
        chk("wd_fault_n", gate(pr, ~pf), wdf_n);
        chk("wd_strobe_n", gate(pr, ~ps), wds_n);
        chk("cs_out_n", gate(pr, pc), cs_out_n);
      end
      chk("reset_hi", ~reset_n, reset_hi);
    end
    stop_test();
  end
endmodule
